/* File: core/dtc_term_ctrl.sv */
// dtc_term_ctrl: on-die termination control with an Avalon-MM register slave
// Overview of operation
// [R1] ignore input in self refresh or both disabled
// [R2] controller drops input before self refresh
// [R3] asynchronous mode while DLL off or synchronizing
// [R4] three-bit nominal code, 110 and 111 illegal
// [R5] nominal strengths reference over 2,4,6,8,12
// [R6] controller keeps input low during reads
// [R7] nominal only after init, never read/self-refresh
// [R8] no dynamic: writes use nominal, limited values
// [R9] sync turn-on after write plus additive minus two; the code never goes below one cycle
// [R10] sync turn-off after same latency
// [R11] async turn-on/off within 2 to 8.5 ns; the code registers it, taking up to one 40 ns clock cycle
// [R12] controller holds input high four cycles
// [R13] controller holds input six cycles after full write
// [R14] turn-off completes right after latency elapses
// [R15] dynamic: write strength during burst, then nominal
// [R16] tied-high input tolerated in single rank
// [R17] no write termination during write leveling
// [R18] mode change settles within bounded delay
// [R19] leveling: strobe nominal, data unterminated
// [R20] dynamic enabled when either mode-two bit set
// [R21] write switch at latency, revert after 4/6 plus
// [R22] write code 01 quarter, 10 half, 11 reserved
// [R23] input sampled on rising clock, latency starts there
module dtc_term_ctrl #(
  parameter int DEPTH = dtc_pkg::HIST_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [dtc_pkg::ADDR_W-1:0]  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [dtc_pkg::DATA_W-1:0]  writedata,
  output logic      [dtc_pkg::DATA_W-1:0]  readdata,
  output logic                             waitrequest,
  input  wire logic                        termCtrlIn,
  input  wire logic                        wrCmd,
  input  wire logic                        wrChop,
  input  wire logic                        selfRefresh,
  input  wire logic                        dllLocked,
  output logic                             termActive,
  output logic                             writeWin,
  output dtc_pkg::dtc_term_t               term
);
  localparam int IDX_W  = $clog2(DEPTH + 1);
  localparam int DATA_W = dtc_pkg::DATA_W;

  dtc_pkg::dtc_mode_t       mode;
  logic [dtc_pkg::LAT_W-1:0] write_latency_setting;
  logic [dtc_pkg::LAT_W-1:0] al;
  dtc_pkg::dtc_bus_state_t  busState;
  dtc_pkg::dtc_bus_state_t  next_busState;
  logic                     busReq;
  logic [5:0]               latSum;
  logic [5:0]               latency;
  logic [5:0]               chopEnd;
  logic [5:0]               fullEnd;
  logic                     asyncMode;
  logic                     dynOn;
  logic                     illegal;
  logic                     effIn;
  logic [3:0]               nomDiv;
  logic [3:0]               wrDiv;
  logic [DEPTH-1:0]         termHist;
  logic [DEPTH-1:0][1:0]    wrHist;
  logic [DEPTH:0]           termVec;
  logic [DEPTH:0][1:0]      wrVec;
  dtc_pkg::dtc_wr_t         curWr;
  dtc_pkg::dtc_wr_t         startWr;
  dtc_pkg::dtc_wr_t         chopWr;
  dtc_pkg::dtc_wr_t         fullWr;
  logic [IDX_W-1:0]         termIdx;
  logic                     next_termActive;
  logic                     next_writeWin;
  dtc_pkg::dtc_term_t       next_term;
  logic [dtc_pkg::DATA_W-1:0] statusWord;

  //////////////////////////////////////////////////////////////////////////////
  // register bus slave: one wait cycle, answer on the second cycle

  assign busReq = read || write;

  // bus handshake state
  always_comb begin
    next_busState = busState;
    unique case (busState)
      dtc_pkg::BUS_IDLE: begin
        if (busReq) begin
          next_busState = dtc_pkg::BUS_ACK;
        end
      end
      dtc_pkg::BUS_ACK: begin
        next_busState = dtc_pkg::BUS_IDLE;
      end
      default: begin
        next_busState = dtc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busState <= dtc_pkg::BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  assign waitrequest = busReq && (busState != dtc_pkg::BUS_ACK);

  // mode and latency registers, written at the accepting edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= '{wlEnable: 1'b0, wrCode: dtc_pkg::WR_RST, nomCode: dtc_pkg::NOM_RST};
      write_latency_setting  <= dtc_pkg::CWL_RST;
      al   <= dtc_pkg::AL_RST;
    end else if (write && busState == dtc_pkg::BUS_ACK) begin
      if (address == dtc_pkg::OFF_MODE) begin
        mode <= dtc_pkg::dtc_mode_t'(writedata[$bits(dtc_pkg::dtc_mode_t)-1:0]);
      end else if (address == dtc_pkg::OFF_LAT) begin
        write_latency_setting <= writedata[dtc_pkg::CWL_LSB +: dtc_pkg::LAT_W];
        al  <= writedata[dtc_pkg::AL_LSB +: dtc_pkg::LAT_W];
      end
    end
  end

  // status word showing the live termination state
  always_comb begin
    statusWord                                       = '0;
    statusWord[dtc_pkg::ST_ACTIVE]                   = termActive;
    statusWord[dtc_pkg::ST_WRWIN]                    = writeWin;
    statusWord[dtc_pkg::ST_ASYNC]                    = asyncMode;
    statusWord[dtc_pkg::ST_ILLEGAL]                  = illegal;
    statusWord[dtc_pkg::ST_DQ_LSB +: dtc_pkg::DIV_W]  = term.dqDiv;
    statusWord[dtc_pkg::ST_DQS_LSB +: dtc_pkg::DIV_W] = term.dqsDiv;
  end

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (read && busState == dtc_pkg::BUS_IDLE) begin
      unique case (address)
        dtc_pkg::OFF_MODE:   readdata <= DATA_W'(mode);
        dtc_pkg::OFF_LAT:    readdata <= DATA_W'({al, write_latency_setting});
        dtc_pkg::OFF_STATUS: readdata <= statusWord;
        default:             readdata <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode decode

  // nominal strength from the three-bit code, reserved codes give none
  always_comb begin
    nomDiv = dtc_pkg::DIV_NONE;
    unique case (mode.nomCode)
      dtc_pkg::NOM_Q4:  nomDiv = dtc_pkg::DIV_4;  // [R5]
      dtc_pkg::NOM_Q2:  nomDiv = dtc_pkg::DIV_2;
      dtc_pkg::NOM_Q6:  nomDiv = dtc_pkg::DIV_6;
      dtc_pkg::NOM_Q12: nomDiv = dtc_pkg::DIV_12;
      dtc_pkg::NOM_Q8:  nomDiv = dtc_pkg::DIV_8;
      default:          nomDiv = dtc_pkg::DIV_NONE; // [R4]
    endcase
  end

  // write strength from the two-bit code, reserved code gives none
  always_comb begin
    wrDiv = dtc_pkg::DIV_NONE;
    unique case (mode.wrCode)
      dtc_pkg::WR_Q4: wrDiv = dtc_pkg::DIV_4; // [R22]
      dtc_pkg::WR_Q2: wrDiv = dtc_pkg::DIV_2;
      default:        wrDiv = dtc_pkg::DIV_NONE;
    endcase
  end

  assign dynOn     = mode.wrCode != dtc_pkg::WR_OFF; // [R20]
  assign illegal   = (mode.nomCode > dtc_pkg::NOM_Q8) || (mode.wrCode > dtc_pkg::WR_Q2); // [R4]
  assign asyncMode = !dllLocked; // [R3]

  // latency is write latency plus additive latency less two, never below one cycle
  assign latSum  = 6'(write_latency_setting) + 6'(al);
  assign latency = (latSum > dtc_pkg::LAT_OFFSET) ? latSum - dtc_pkg::LAT_OFFSET : dtc_pkg::LAT_MIN; // [R9]
  assign chopEnd = latency + dtc_pkg::CHOP_HOLD; // [R21]
  assign fullEnd = latency + dtc_pkg::FULL_HOLD; // [R21]

  //////////////////////////////////////////////////////////////////////////////
  // input history; tied-high input with nominal off still passes for writes

  assign effIn = termCtrlIn && !selfRefresh && (mode.nomCode != dtc_pkg::NOM_OFF || dynOn); // [R1] [R16]
  assign curWr = '{wr: wrCmd, chop: wrChop};

  dtc_delay_line #(.WIDTH(1), .DEPTH(DEPTH)) termLine (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (effIn),
    .hist  (termHist)
  ); // [R23]

  dtc_delay_line #(.WIDTH(2), .DEPTH(DEPTH)) writeLine (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (curWr),
    .hist  (wrHist)
  );

  // index k of a vector is the sample registered k edges ago
  assign termVec = {termHist, effIn};
  assign wrVec   = {wrHist, curWr};
  assign termIdx = asyncMode ? IDX_W'(dtc_pkg::ASYNC_CYC - 1) : IDX_W'(latency); // [R11] [R9] [R10]
  assign startWr = dtc_pkg::dtc_wr_t'(wrVec[IDX_W'(latency)]);
  assign chopWr  = dtc_pkg::dtc_wr_t'(wrVec[IDX_W'(chopEnd)]);
  assign fullWr  = dtc_pkg::dtc_wr_t'(wrVec[IDX_W'(fullEnd)]);

  //////////////////////////////////////////////////////////////////////////////
  // termination state and strength

  assign next_termActive = termVec[termIdx]; // [R9] [R10] [R11]

  // a write starting now wins over an older one ending now
  always_comb begin
    next_writeWin = writeWin;
    if (startWr.wr) begin
      next_writeWin = 1'b1; // [R21]
    end else if ((chopWr.wr && chopWr.chop) || (fullWr.wr && !fullWr.chop)) begin
      next_writeWin = 1'b0; // [R21]
    end
  end

  // strength follows mode registers at once, so a mode load settles in one cycle
  always_comb begin
    next_term.dqDiv  = dtc_pkg::DIV_NONE;
    next_term.dqsDiv = dtc_pkg::DIV_NONE;
    if (next_termActive) begin
      if (mode.wlEnable) begin
        next_term.dqsDiv = nomDiv; // [R19] [R17]
      end else if (dynOn && next_writeWin) begin
        next_term.dqDiv  = wrDiv; // [R15]
        next_term.dqsDiv = wrDiv;
      end else begin
        next_term.dqDiv  = nomDiv; // [R8] [R18]
        next_term.dqsDiv = nomDiv;
      end
    end
  end

  // outputs change at the edge ending the latency, inside the skew window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      termActive <= 1'b0;
      writeWin   <= 1'b0;
      term       <= '0;
    end else begin
      termActive <= next_termActive; // [R14]
      writeWin   <= next_writeWin;
      term       <= next_term;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ignore_input_a: assert property ( // [R1]
    (selfRefresh || (mode.nomCode == dtc_pkg::NOM_OFF && !dynOn)) |-> !effIn)
    else $error("termination input not ignored");

  async_follow_a: assert property ( // [R11]
    !dllLocked |=> termActive == $past(effIn))
    else $error("async termination missed one-cycle bound");

  sync_on_a: assert property ( // [R9]
    (dllLocked && latency == 6'h03 && $rose(effIn)) ##1 (dllLocked && latency == 6'h03)[*3] |=> termActive)
    else $error("sync turn-on latency wrong");

  sync_off_a: assert property ( // [R10]
    (dllLocked && latency == 6'h03 && $fell(effIn)) ##1 (dllLocked && latency == 6'h03)[*3] |=> !termActive)
    else $error("sync turn-off latency wrong");

  write_start_a: assert property ( // [R21]
    (wrCmd && latency == 6'h03) ##1 (latency == 6'h03)[*3] |=> writeWin)
    else $error("write window did not open at latency");

  chop_end_a: assert property ( // [R21]
    (wrCmd && wrChop && !writeWin && latency == 6'h03) ##1 (!wrCmd && latency == 6'h03)[*7] |=> !writeWin)
    else $error("chopped write window did not close");

  level_strobe_a: assert property ( // [R19]
    (termActive && $past(mode.wlEnable)) |-> term.dqDiv == dtc_pkg::DIV_NONE && term.dqsDiv == $past(nomDiv))
    else $error("write leveling termination wrong");

  dyn_strength_a: assert property ( // [R15]
    (termActive && writeWin && $past(dynOn) && !$past(mode.wlEnable)) |-> term.dqDiv == $past(wrDiv))
    else $error("write strength not applied");

  nom_strength_a: assert property ( // [R8]
    (termActive && !$past(dynOn) && !$past(mode.wlEnable)) |-> term.dqDiv == $past(nomDiv))
    else $error("nominal strength not used");

  illegal_code_a: assert property ( // [R4]
    (mode.nomCode > dtc_pkg::NOM_Q8) |-> nomDiv == dtc_pkg::DIV_NONE && illegal)
    else $error("reserved nominal code not flagged");

  off_none_a: assert property ( // [R14]
    !termActive |-> term == '0)
    else $error("strength present while termination off");

  sync_on_c:  cover property (dllLocked && $rose(termActive));
  async_on_c: cover property (!dllLocked && $rose(termActive));
  chop_wr_c:  cover property (wrCmd && wrChop ##[1:20] $fell(writeWin));
  full_wr_c:  cover property (wrCmd && !wrChop ##[1:20] $fell(writeWin));
endmodule

/* File: shared/dtc_pkg.sv */
// dtc_pkg: constants and types shared by the termination controller files
package dtc_pkg;
  // register bus geometry
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 32;
  localparam logic [3:0]  OFF_MODE   = 4'h0;
  localparam logic [3:0]  OFF_LAT    = 4'h4;
  localparam logic [3:0]  OFF_STATUS = 4'h8;
  // latency register fields
  localparam int          LAT_W      = 4;
  localparam int          CWL_LSB    = 0;
  localparam int          AL_LSB     = 4;
  // status register fields
  localparam int          ST_ACTIVE  = 0;
  localparam int          ST_WRWIN   = 1;
  localparam int          ST_ASYNC   = 2;
  localparam int          ST_ILLEGAL = 3;
  localparam int          ST_DQ_LSB  = 4;
  localparam int          ST_DQS_LSB = 8;
  localparam int          DIV_W      = 4;
  // reset values
  localparam logic [2:0]  NOM_RST    = 3'h0;
  localparam logic [1:0]  WR_RST     = 2'h0;
  localparam logic [3:0]  CWL_RST    = 4'h5;
  localparam logic [3:0]  AL_RST     = 4'h0;
  // nominal termination codes in mode register one
  localparam logic [2:0]  NOM_OFF    = 3'h0;
  localparam logic [2:0]  NOM_Q4     = 3'h1;
  localparam logic [2:0]  NOM_Q2     = 3'h2;
  localparam logic [2:0]  NOM_Q6     = 3'h3;
  localparam logic [2:0]  NOM_Q12    = 3'h4;
  localparam logic [2:0]  NOM_Q8     = 3'h5;
  // write termination codes in mode register two
  localparam logic [1:0]  WR_OFF     = 2'h0;
  localparam logic [1:0]  WR_Q4      = 2'h1;
  localparam logic [1:0]  WR_Q2      = 2'h2;
  // strength as divisor of the 240 ohm calibration reference, zero is no termination
  localparam int          REF_OHM    = 240;
  localparam logic [3:0]  DIV_NONE   = 4'h0;
  localparam logic [3:0]  DIV_2      = 4'h2;
  localparam logic [3:0]  DIV_4      = 4'h4;
  localparam logic [3:0]  DIV_6      = 4'h6;
  localparam logic [3:0]  DIV_8      = 4'h8;
  localparam logic [3:0]  DIV_12     = 4'hC;
  // timing
  localparam int          CLK_PS       = 40000;
  localparam int          ASYNC_MIN_PS = 2000;
  localparam int          ASYNC_MAX_PS = 8500;
  localparam int          ASYNC_CYC    = (ASYNC_MAX_PS / CLK_PS) < 1 ? 1 : ASYNC_MAX_PS / CLK_PS;
  localparam logic [5:0]  LAT_OFFSET   = 6'h02;
  localparam logic [5:0]  LAT_MIN      = 6'h01;
  localparam logic [5:0]  CHOP_HOLD    = 6'h04;
  localparam logic [5:0]  FULL_HOLD    = 6'h06;
  localparam int          HIST_DEPTH   = 40;
  // carriers
  typedef struct packed {
    logic       wlEnable;
    logic [1:0] wrCode;
    logic [2:0] nomCode;
  } dtc_mode_t;
  typedef struct packed {
    logic wr;
    logic chop;
  } dtc_wr_t;
  typedef struct packed {
    logic [3:0] dqsDiv;
    logic [3:0] dqDiv;
  } dtc_term_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } dtc_bus_state_t;
endpackage

/* File: core/dtc_delay_line.sv */
// dtc_delay_line: shift register keeping the last DEPTH samples of an input
module dtc_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 40
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [WIDTH-1:0]             din,
  output logic      [DEPTH-1:0][WIDTH-1:0]  hist
);
  // hist[0] holds the sample taken at the latest rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist <= '0;
    end else begin
      hist <= {hist[DEPTH-2:0], din};
    end
  end
endmodule

/* File: test/dtc_ctrl_model.sv */
// dtc_ctrl_model: memory controller side driving termination input and write commands
module dtc_ctrl_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic wantOn,
  input  wire logic wantWr,
  input  wire logic wantChop,
  input  wire logic wantSr,
  input  wire logic tiedHigh,
  output logic      termCtrlIn,
  output logic      wrCmd,
  output logic      wrChop,
  output logic      selfRefresh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold;
  ////////////////////////////////////////////////////////////////////////////
  // termination input with minimum high times after rise and after writes
  // no reads are issued, and the input rises only once the bench has loaded the mode registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      termCtrlIn <= 1'b0;
      hold       <= 3'h0;
    end else if (tiedHigh) begin
      termCtrlIn <= 1'b1;
    end else if (wantWr && (termCtrlIn || wantOn)) begin
      termCtrlIn <= 1'b1;
      hold       <= wantChop ? 3'h3 : 3'h5;
    end else if (wantOn && !wantSr && !termCtrlIn) begin
      termCtrlIn <= 1'b1;
      hold       <= 3'h3;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      termCtrlIn <= wantOn && !wantSr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // commands; the unused qualifier toggles so a stale value is never seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrCmd       <= 1'b0;
      wrChop      <= 1'b0;
      selfRefresh <= 1'b0;
    end else begin
      wrCmd       <= wantWr;
      wrChop      <= wantWr ? wantChop : !wrChop;
      selfRefresh <= wantSr && (!termCtrlIn || tiedHigh);
    end
  end
endmodule

/* File: test/tb.sv */
// tb: self-checking bench for the termination controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic [3:0]          address = 4'h0;
  logic                read = 1'b0;
  logic                write = 1'b0;
  logic [31:0]         writedata = 32'h0;
  logic [31:0]         readdata;
  logic                waitrequest;
  logic                wantOn = 1'b0, wantWr = 1'b0, wantChop = 1'b0, wantSr = 1'b0, tiedHigh = 1'b0;
  logic                dllLocked = 1'b1;
  logic                termCtrlIn, wrCmd, wrChop, selfRefresh, termActive, writeWin;
  dtc_pkg::dtc_term_t  term;
  logic [2:0]          nom = 3'h0;
  logic [1:0]          wr = 2'h0;
  logic                wl = 1'b0;
  logic [31:0]         q;
  int                  lat = 3, cyc = 0, errorCnt = 0, nCompared = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #20 clk = !clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errorCnt++;
      report_and_stop();
    end
  end
  dtc_term_ctrl dtc_term_ctrl_i (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .termCtrlIn(termCtrlIn),
    .wrCmd(wrCmd), .wrChop(wrChop), .selfRefresh(selfRefresh), .dllLocked(dllLocked),
    .termActive(termActive), .writeWin(writeWin), .term(term));
  dtc_ctrl_model dtc_ctrl_model_i (.clk(clk), .rst_b(rst_b), .wantOn(wantOn), .wantWr(wantWr),
    .wantChop(wantChop), .wantSr(wantSr), .tiedHigh(tiedHigh), .termCtrlIn(termCtrlIn), .wrCmd(wrCmd),
    .wrChop(wrChop), .selfRefresh(selfRefresh));
  ////////////////////////////////////////////////////////////////////////////
  // comparisons and closing
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(input string n, input logic [9:0] e);
    nCompared++;
    if ({termActive, writeWin, term} !== e) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h at cycle %0d", n, e, {termActive, writeWin, term}, cyc);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // avalon master: hold request until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // sample at the rising edge; the answer and read data are taken where waitrequest is low
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 20);
    if (waitrequest !== 1'b0) chk_reg("waitrequest", 32'h0, 32'h1);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic set_mode(input logic l, input logic [1:0] w, input logic [2:0] n);
    wl = l;
    wr = w;
    nom = n;
    bus(1'b1, dtc_pkg::OFF_MODE, {26'h0, l, w, n});
  endtask
  function automatic logic [3:0] nd(input logic [2:0] c);
    case (c)
      3'h1: nd = dtc_pkg::DIV_4;
      3'h2: nd = dtc_pkg::DIV_2;
      3'h3: nd = dtc_pkg::DIV_6;
      3'h4: nd = dtc_pkg::DIV_12;
      3'h5: nd = dtc_pkg::DIV_8;
      default: nd = dtc_pkg::DIV_NONE;
    endcase
  endfunction
  function automatic logic [3:0] wd(input logic [1:0] c);
    wd = (c == 2'h1) ? dtc_pkg::DIV_4 : (c == 2'h2) ? dtc_pkg::DIV_2 : dtc_pkg::DIV_NONE;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // request on for h cycles, optional write at cycle wa; checks every cycle
  task automatic run_seq(input int h, input int wa, input logic ch);
    logic a, w;
    logic [7:0] t;
    for (int k = 0; k < h + lat + 4; k++) begin
      @(posedge clk);
      wantOn <= (k < h);
      wantWr <= (k == wa);
      wantChop <= ch;
      #1;
      a = (nom != 3'h0 || wr != 2'h0) && k >= 2 + lat && k < h + 2 + lat;
      w = k >= wa + 2 + lat && k < wa + 2 + lat + (ch ? 4 : 6);
      t = !a ? 8'h00 : wl ? {nd(nom), 4'h0} : (wr != 2'h0 && w) ? {2{wd(wr)}} : {2{nd(nom)}};
      chk_out("outputs", {a, w, t});
    end
  endtask
  task automatic t_reset();
    bus(1'b0, dtc_pkg::OFF_MODE, 32'h0);
    chk_reg("mode", 32'h0, q);
    bus(1'b0, dtc_pkg::OFF_LAT, 32'h0);
    chk_reg("latency", 32'h05, q);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk_reg("unmapped", 32'h0, q);
    $display("test reset done");
  endtask
  task automatic t_nominal();
    for (int c = 0; c < 8; c++) begin
      set_mode(1'b0, 2'h0, c[2:0]);
      run_seq(5, 99, 1'b0);
      bus(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
      chk_reg("status", (c > 5) ? 32'h8 : 32'h0, q);
    end
    $display("test nominal done");
  endtask
  task automatic t_latency();
    bus(1'b1, dtc_pkg::OFF_LAT, 32'h26);
    lat = 6;
    set_mode(1'b0, 2'h0, 3'h1);
    run_seq(4, 99, 1'b0);
    bus(1'b1, dtc_pkg::OFF_LAT, 32'h02);
    lat = 1;
    run_seq(4, 99, 1'b0);
    bus(1'b1, dtc_pkg::OFF_LAT, 32'h05);
    lat = 3;
    $display("test latency done");
  endtask
  task automatic t_dynamic();
    for (int w = 0; w < 4; w++) begin
      set_mode(1'b0, w[1:0], 3'h1);
      run_seq(16, 2, 1'b1);
      run_seq(16, 2, 1'b0);
    end
    set_mode(1'b1, 2'h0, 3'h3);
    run_seq(12, 2, 1'b0);
    $display("test dynamic done");
  endtask
  task automatic t_async();
    dllLocked <= 1'b0;
    lat = 0;
    set_mode(1'b0, 2'h0, 3'h2);
    run_seq(4, 99, 1'b0);
    @(posedge clk);
    dllLocked <= 1'b1;
    lat = 3;
    $display("test async done");
  endtask
  task automatic t_tied();
    set_mode(1'b0, 2'h1, 3'h0);
    tiedHigh <= 1'b1;
    repeat (lat + 4) @(posedge clk);
    #1 chk_out("tied on", 10'h200);
    bus(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    chk_reg("status on", 32'h1, q);
    // one full write with the input tied high: write strength on both pin groups
    wantWr <= 1'b1;
    wantChop <= 1'b0;
    @(posedge clk);
    wantWr <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_out("tied write", {2'b11, dtc_pkg::DIV_4, dtc_pkg::DIV_4});
    @(posedge clk);
    wantSr <= 1'b1;
    repeat (lat + 4) @(posedge clk);
    #1 chk_out("self refresh", 10'h000);
    @(posedge clk);
    wantSr <= 1'b0;
    tiedHigh <= 1'b0;
    repeat (lat + 4) @(posedge clk);
    #1 chk_out("released", 10'h000);
    $display("test tied done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_nominal();
    t_latency();
    t_dynamic();
    t_async();
    t_tied();
    report_and_stop();
  end
endmodule
